// ==== rtl/mei2_pkg.sv ====
package mei2_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int unsigned ADR_W   = 8;
  localparam int unsigned DAT_W   = 32;
  localparam int unsigned SEL_W   = 4;
  localparam int unsigned EVT_W   = 6;
  localparam int unsigned FIELD_W = 7;
  localparam int unsigned SAMP_W  = 8;
  localparam int unsigned IRQ_W   = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONFIG     = 8'h34;
  localparam logic [7:0] IDX_SOURCE     = 8'h35;
  localparam logic [7:0] IDX_THRESHOLD  = 8'h36;
  localparam logic [7:0] IDX_DURATION   = 8'h37;
  localparam logic [7:0] IDX_CONTROL    = 8'h38;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h39;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h3A;
  localparam logic [7:0] IDX_IRQ_CLEAR  = 8'h3B;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned CFG_AND_OR_BIT = 7;
  localparam int unsigned CFG_SIXDIR_BIT = 6;
  localparam int unsigned SRC_ACTIVE_BIT = 6;
  localparam int unsigned CTRL_LATCH_BIT = 0;
  localparam int unsigned IRQ_EVENT_BIT  = 0;
  localparam int unsigned IRQ_DROP_BIT   = 1;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0]         CONFIG_RST    = 8'h00;
  localparam logic [FIELD_W-1:0] THRESHOLD_RST = 7'h00;
  localparam logic [FIELD_W-1:0] DURATION_RST  = 7'h00;
  localparam logic [EVT_W-1:0]   FLAGS_RST     = 6'h00;
  localparam logic [IRQ_W-1:0]   IRQ_RST       = 2'h0;
  localparam logic [FIELD_W-1:0] COUNT_MAX     = 7'h7F;

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt modes
  typedef enum logic [3:0] {
    MODE_OR   = 4'b0001,
    MODE_MOVE = 4'b0010,
    MODE_AND  = 4'b0100,
    MODE_POS  = 4'b1000
  } mei2_mode_t;

endpackage : mei2_pkg

// ==== rtl/mei2_top.sv ====
`timescale 1ns/1ps
// Summary of operation
// - A config bit selects AND or OR combining of enabled events and resets to 0.
// - A six-direction enable bit resets to 0 and picks the mode together with 's bit.
// - Each axis above-enable requests an interrupt when the sample magnitude exceeds the threshold, or with six-direction when the sample exceeds it.
// - Each axis below-enable requests an interrupt when the sample magnitude is under the threshold, or with six-direction when the sample is under its negative.
// - Without six-direction, OR fires on any enabled event and AND needs all of them.
// - With six-direction, combine 0 is movement recognition and combine 1 position.
// - The active flag is 1 once an interrupt was generated, else 0, and resets to 0.
// - Six per-event flags report which events occurred and reset to 0.
// - The source register is read only and its top bit reads 0.
// - Reading the source register clears the active flag and drops the pin.
// - In latched mode the source register is frozen until read, then may refresh.
// - The threshold is a 7-bit field resetting to zero with bit 7 reading 0.
// - A 7-bit duration resetting to zero sets how long a condition must last.
// - Duration is counted in sample periods so it scales with the data rate.
// - Axis samples are 8-bit two's complement values.
module mei2_top
  import mei2_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [SEL_W-1:0] wb_sel_i,
  input  wire logic [DAT_W-1:0] wb_dat_i,
  output logic      [DAT_W-1:0] wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             sample_valid_i,
  input  wire logic [SAMP_W-1:0] accel_x_i,
  input  wire logic [SAMP_W-1:0] accel_y_i,
  input  wire logic [SAMP_W-1:0] accel_z_i,
  output logic                  int2_o,
  output logic                  irq_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic reg_hit(input logic [ADR_W-1:0] adr,
                                   input logic [7:0]       idx);
    return adr == {idx[5:0], 2'b00};
  endfunction : reg_hit

  function automatic logic [SAMP_W:0] magnitude(input logic [SAMP_W-1:0] s);
    logic [SAMP_W:0] ext;
    ext = {s[SAMP_W-1], s};
    return s[SAMP_W-1] ? 9'(-ext) : ext;
  endfunction : magnitude

  ////////////////////////////////////////////////////////////////////////////////
  // State

  logic [7:0]         config_q;
  logic [FIELD_W-1:0] threshold_q;
  logic [FIELD_W-1:0] duration_q;
  logic               latch_en;
  logic               interrupt_active_flag;
  logic [EVT_W-1:0]   flags;
  logic [FIELD_W-1:0] run_cnt;
  logic [EVT_W-1:0]   prev_dir;
  logic [IRQ_W-1:0]   irq_status;
  logic [IRQ_W-1:0]   irq_enable;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic hit_cfg;
  logic hit_src;
  logic hit_ths;
  logic hit_dur;
  logic hit_ctl;
  logic hit_ist;
  logic hit_ien;
  logic hit_icl;
  logic src_rd;

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Only lane 0 carries register bits; other lanes are ignored
  assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
  assign bus_rd  = bus_req & ~wb_we_i;
  assign hit_cfg = reg_hit(wb_adr_i, IDX_CONFIG);
  assign hit_src = reg_hit(wb_adr_i, IDX_SOURCE);
  assign hit_ths = reg_hit(wb_adr_i, IDX_THRESHOLD);
  assign hit_dur = reg_hit(wb_adr_i, IDX_DURATION);
  assign hit_ctl = reg_hit(wb_adr_i, IDX_CONTROL);
  assign hit_ist = reg_hit(wb_adr_i, IDX_IRQ_STATUS);
  assign hit_ien = reg_hit(wb_adr_i, IDX_IRQ_ENABLE);
  assign hit_icl = reg_hit(wb_adr_i, IDX_IRQ_CLEAR);
  assign src_rd  = bus_rd & hit_src;

  ////////////////////////////////////////////////////////////////////////////////
  // Axis comparators

  logic [3*SAMP_W-1:0] axes;
  logic [EVT_W-1:0]    ev_mag;
  logic [EVT_W-1:0]    ev_dir;
  logic [SAMP_W:0]     thr_ext;

  assign axes    = {accel_z_i, accel_y_i, accel_x_i};
  assign thr_ext = {2'b00, threshold_q};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_axis
      logic [SAMP_W-1:0] smp;
      logic [SAMP_W:0]   mag;
      logic [SAMP_W:0]   sext;
      assign smp  = axes[gi*SAMP_W +: SAMP_W];
      assign mag  = magnitude(smp);
      assign sext = {smp[SAMP_W-1], smp};
      assign ev_mag[2*gi+1] = mag > thr_ext;
      assign ev_mag[2*gi]   = mag < thr_ext;
      // Directional view keeps the sign, for six-direction modes
      assign ev_dir[2*gi+1] = $signed(sext) > $signed(thr_ext);
      assign ev_dir[2*gi]   = $signed(sext) < -$signed(thr_ext);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Mode selection and combining

  logic             and_or_select;
  logic             six_dir;
  logic [EVT_W-1:0] enables;
  mei2_mode_t       mode;
  logic [EVT_W-1:0] pattern;
  logic             cond;

  assign and_or_select = config_q[CFG_AND_OR_BIT];
  assign six_dir       = config_q[CFG_SIXDIR_BIT];
  assign enables       = config_q[EVT_W-1:0];
  assign mode          = and_or_select ? (six_dir ? MODE_POS  : MODE_AND)
                                       : (six_dir ? MODE_MOVE : MODE_OR);

  always_comb begin
    pattern = FLAGS_RST;
    cond    = 1'b0;
    unique case (mode)
      MODE_OR: begin
        pattern = ev_mag & enables;
        cond    = |pattern;
      end
      MODE_AND: begin
        pattern = ev_mag & enables;
        cond    = (enables != FLAGS_RST) && (pattern == enables);
      end
      MODE_MOVE: begin
        pattern = ev_dir & enables;
        cond    = (|pattern) && (pattern != prev_dir);
      end
      MODE_POS: begin
        pattern = ev_dir & enables;
        cond    = |pattern;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Duration qualification

  logic               qualified;
  logic [FIELD_W-1:0] next_run_cnt;

  // condition must last the programmed samples
  assign qualified    = cond && (run_cnt >= duration_q);
  // count consecutive samples, restart on drop
  assign next_run_cnt = !cond ? 7'h00 :
                        (run_cnt == COUNT_MAX) ? run_cnt : 7'(run_cnt + 7'h01);

  // advanced once per data-rate sample only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_cnt  <= 7'h00;
      prev_dir <= FLAGS_RST;
    end else if (sample_valid_i) begin
      run_cnt  <= next_run_cnt;
      if (qualified || (pattern == FLAGS_RST)) begin
        prev_dir <= pattern;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Source register update

  logic             frozen;
  logic             set_active;
  logic             clr_active;
  logic             load_flags;
  logic             next_active;
  logic [EVT_W-1:0] next_flags;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  assign frozen      = latch_en & interrupt_active_flag;
  assign set_active  = sample_valid_i & qualified & ~frozen;
  assign load_flags  = set_active | (sample_valid_i & ~latch_en & ~qualified);
  // a source read clears the active flag
  assign clr_active  = src_rd | (sample_valid_i & ~latch_en & ~qualified);
  // A new event in the read cycle wins over the clear
  assign next_active = set_active ? 1'b1 : (clr_active ? 1'b0 : interrupt_active_flag);
  assign next_flags  = set_active ? pattern : FLAGS_RST;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interrupt_active_flag <= 1'b0;
      flags                 <= FLAGS_RST;
    end else begin
      interrupt_active_flag <= next_active;
      if (load_flags) begin
        flags <= next_flags;
      end
    end
  end

  assign int2_o = interrupt_active_flag;

  ////////////////////////////////////////////////////////////////////////////////
  // Host interrupt status

  assign irq_set[IRQ_EVENT_BIT] = set_active & ~interrupt_active_flag;
  // Events lost while frozen are counted as a drop
  assign irq_set[IRQ_DROP_BIT]  = sample_valid_i & frozen & qualified;
  assign irq_clr = (bus_wr & hit_icl) ? wb_dat_i[IRQ_W-1:0] : IRQ_RST;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= IRQ_RST;
    end else begin
      irq_status <= irq_set | (irq_status & ~irq_clr);
    end
  end

  assign irq_o = |(irq_status & irq_enable);

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes

  // no write path into the source register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      config_q    <= CONFIG_RST;
      threshold_q <= THRESHOLD_RST;
      duration_q  <= DURATION_RST;
      latch_en    <= 1'b0;
      irq_enable  <= IRQ_RST;
    end else if (bus_wr) begin
      if (hit_cfg) begin
        config_q <= wb_dat_i[7:0];
      end
      if (hit_ths) begin
        threshold_q <= wb_dat_i[FIELD_W-1:0];
      end
      if (hit_dur) begin
        duration_q <= wb_dat_i[FIELD_W-1:0];
      end
      if (hit_ctl) begin
        latch_en <= wb_dat_i[CTRL_LATCH_BIT];
      end
      if (hit_ien) begin
        irq_enable <= wb_dat_i[IRQ_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux and acknowledge

  logic [7:0]       src_byte;
  logic [DAT_W-1:0] rd_word;

  // top bit of the source reads 0
  assign src_byte = {1'b0, interrupt_active_flag, flags};
  assign rd_word  = hit_cfg ? {24'h00_0000, config_q} :
                    hit_src ? {24'h00_0000, src_byte} :
                    hit_ths ? {25'h000_0000, threshold_q} :
                    hit_dur ? {25'h000_0000, duration_q} :
                    hit_ctl ? {31'h0000_0000, latch_en} :
                    hit_ist ? {30'h0000_0000, irq_status} :
                    hit_ien ? {30'h0000_0000, irq_enable} :
                    32'h0000_0000;

  // Unmapped addresses still answer, with zero data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_rd) begin
        wb_dat_o <= rd_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  logic rd_src_q;
  logic rd_ths_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_src_q <= 1'b0;
      rd_ths_q <= 1'b0;
    end else begin
      rd_src_q <= src_rd;
      rd_ths_q <= bus_rd & hit_ths;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_active_on_event: assert property (set_active |=> interrupt_active_flag && int2_o)
    else $error("active flag not set after qualified sample");

  a_read_clears_pin: assert property (src_rd && !set_active |=> !int2_o)
    else $error("source read did not drop the pin");

  a_latch_freeze: assert property (frozen && !src_rd |=>
    $stable(flags) && interrupt_active_flag)
    else $error("latched source changed before read");

  a_unlatched_drop: assert property (sample_valid_i && !latch_en && !qualified |=>
    !interrupt_active_flag && flags == FLAGS_RST)
    else $error("unlatched source did not follow condition");

  a_duration_block: assert property (sample_valid_i && cond && run_cnt < duration_q &&
    !interrupt_active_flag && !src_rd |=> !interrupt_active_flag)
    else $error("event recognised before duration elapsed");

  a_count_restart: assert property (sample_valid_i && !cond |=> run_cnt == 7'h00)
    else $error("duration count not restarted");

  a_and_all: assert property (mode == MODE_AND && cond |-> (ev_mag & enables) == enables)
    else $error("AND mode fired without all events");

  a_or_any: assert property (mode == MODE_OR && |(ev_mag & enables) |-> cond)
    else $error("OR mode missed an enabled event");

  a_flags_enabled: assert property (set_active |=>
    (flags & ~$past(enables)) == FLAGS_RST)
    else $error("flag set for a disabled event");

  a_move_new: assert property (mode == MODE_MOVE && cond |-> pattern != prev_dir)
    else $error("movement fired without direction change");

  a_src_msb: assert property (rd_src_q |-> wb_ack_o && !wb_dat_o[7])
    else $error("source register top bit not zero");

  a_ths_msb: assert property (rd_ths_q |-> wb_dat_o[7] == 1'b0)
    else $error("threshold register top bit not zero");

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held longer than one cycle");

  c_and_event:  cover property (set_active && mode == MODE_AND);
  c_pos_event:  cover property (set_active && mode == MODE_POS);
  c_move_event: cover property (set_active && mode == MODE_MOVE);
  c_drop_event: cover property (irq_set[IRQ_DROP_BIT]);
  c_read_clear: cover property (src_rd && interrupt_active_flag ##1 !interrupt_active_flag);

endmodule : mei2_top

// ==== dv/mei2_sample_src.sv ====
`timescale 1ns/1ps
module mei2_sample_src
  import mei2_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              fire_i,
  input  wire logic [SAMP_W-1:0] x_i,
  input  wire logic [SAMP_W-1:0] y_i,
  input  wire logic [SAMP_W-1:0] z_i,
  output logic                   sample_valid_o = 1'b0,
  output logic      [SAMP_W-1:0] accel_x_o      = 8'h00,
  output logic      [SAMP_W-1:0] accel_y_o      = 8'h00,
  output logic      [SAMP_W-1:0] accel_z_o      = 8'h00
);
  // one tick per sample, 8-bit two's complement
  always @(posedge clk_i) begin
    if (rst_i) begin
      sample_valid_o <= 1'b0;
    end else if (fire_i) begin
      sample_valid_o <= 1'b1;
      accel_x_o      <= x_i;
      accel_y_o      <= y_i;
      accel_z_o      <= z_i;
    end else begin
      // Not held between ticks, so a stale sample cannot pass unnoticed
      sample_valid_o <= 1'b0;
      accel_x_o      <= ~accel_x_o;
      accel_y_o      <= ~accel_y_o;
      accel_z_o      <= ~accel_z_o;
    end
  end
endmodule : mei2_sample_src

// ==== dv/test_motion_event_interrupt_two.sv ====
`timescale 1ns/1ps
module test_motion_event_interrupt_two;
  import mei2_pkg::*;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              cyc   = 1'b0;
  logic              stb   = 1'b0;
  logic              we    = 1'b0;
  logic [ADR_W-1:0]  adr   = 8'h00;
  logic [SEL_W-1:0]  sel   = 4'h0;
  logic [DAT_W-1:0]  wdat  = 32'h0000_0000;
  logic              fire  = 1'b0;
  logic [SAMP_W-1:0] fx    = 8'h00;
  logic [SAMP_W-1:0] fy    = 8'h00;
  logic [SAMP_W-1:0] fz    = 8'h00;
  logic [DAT_W-1:0]  rdat;
  logic              ack;
  logic              svalid;
  logic [SAMP_W-1:0] ax;
  logic [SAMP_W-1:0] ay;
  logic [SAMP_W-1:0] az;
  logic              int2;
  logic              irq;
  logic [DAT_W-1:0]  rd;
  int                err_count  = 0;
  int                n_compared = 0;

  always #20 clk_i = ~clk_i;

  mei2_sample_src mei2_sample_src_i (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .x_i(fx),
    .y_i(fy), .z_i(fz), .sample_valid_o(svalid), .accel_x_o(ax), .accel_y_o(ay),
    .accel_z_o(az));
  mei2_top mei2_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .sample_valid_i(svalid), .accel_x_i(ax), .accel_y_i(ay),
    .accel_z_i(az), .int2_o(int2), .irq_o(irq));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_reg(input string what, input logic [DAT_W-1:0] exp,
                         input logic [DAT_W-1:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_reg

  task automatic chk_pin(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_pin

  // Classic cycle; entered just after a rising edge, waits for ack with a bound
  task automatic wb(input logic w, input logic [7:0] idx, input logic [DAT_W-1:0] d);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx[5:0], 2'b00};
    sel  <= 4'hF;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = rdat;
    chk_pin("wb_ack_o", 1'b1, ack);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic rdchk(input logic [7:0] idx, input logic [DAT_W-1:0] exp);
    wb(1'b0, idx, 32'h0000_0000);
    chk_reg($sformatf("reg %h", idx), exp, rd);
  endtask : rdchk

  // Partner registers the tick, design takes it one edge later, then let it settle
  task automatic smp(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
    fire <= 1'b1;
    fx   <= x;
    fy   <= y;
    fz   <= z;
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : smp

  // Quiet sample with nothing enabled clears flags, flag run and movement history
  task automatic cfg(input logic [7:0] c, input logic [7:0] t, input logic [7:0] d);
    wb(1'b1, IDX_CONFIG, 32'h0000_0000);
    smp(8'h00, 8'h00, 8'h00);
    wb(1'b0, IDX_SOURCE, 32'h0000_0000);
    wb(1'b1, IDX_THRESHOLD, {24'h00_0000, t});
    wb(1'b1, IDX_DURATION, {24'h00_0000, d});
    wb(1'b1, IDX_CONFIG, {24'h00_0000, c});
  endtask : cfg

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rdchk(IDX_CONFIG, 32'h0000_0000);
    rdchk(IDX_SOURCE, 32'h0000_0000);
    rdchk(IDX_THRESHOLD, 32'h0000_0000);
    rdchk(IDX_DURATION, 32'h0000_0000);
    wb(1'b1, IDX_THRESHOLD, 32'h0000_00FF);
    rdchk(IDX_THRESHOLD, 32'h0000_007F);
    wb(1'b1, IDX_DURATION, 32'h0000_00FF);
    rdchk(IDX_DURATION, 32'h0000_007F);
    wb(1'b1, IDX_SOURCE, 32'h0000_00FF);
    rdchk(IDX_SOURCE, 32'h0000_0000);
    wb(1'b1, IDX_CONFIG, 32'h0000_00C3);
    rdchk(IDX_CONFIG, 32'h0000_00C3);
    wb(1'b1, 8'h3C, 32'h0000_00FF);
    rdchk(8'h3C, 32'h0000_0000);
    $display("test regs done");
  endtask : t_regs

  task automatic t_or();
    cfg(8'h02, 8'h20, 8'h00);
    smp(8'h30, 8'h00, 8'h00);
    chk_pin("int2_o", 1'b1, int2);
    rdchk(IDX_SOURCE, 32'h0000_0042);
    chk_pin("int2_o", 1'b0, int2);
    rdchk(IDX_SOURCE, 32'h0000_0002);
    smp(8'h00, 8'h7F, 8'h80);
    rdchk(IDX_SOURCE, 32'h0000_0000);
    smp(8'hD0, 8'h00, 8'h00);
    rdchk(IDX_SOURCE, 32'h0000_0042);
    cfg(8'h01, 8'h20, 8'h00);
    smp(8'h10, 8'h70, 8'h70);
    rdchk(IDX_SOURCE, 32'h0000_0041);
    smp(8'h20, 8'h00, 8'h00);
    rdchk(IDX_SOURCE, 32'h0000_0000);
    $display("test or_mode done");
  endtask : t_or

  task automatic t_and();
    cfg(8'h8A, 8'h20, 8'h00);
    smp(8'h30, 8'h00, 8'h00);
    rdchk(IDX_SOURCE, 32'h0000_0000);
    smp(8'h30, 8'h30, 8'h00);
    rdchk(IDX_SOURCE, 32'h0000_004A);
    $display("test and_mode done");
  endtask : t_and

  task automatic t_dur();
    cfg(8'h02, 8'h20, 8'h02);
    smp(8'h30, 8'h00, 8'h00);
    smp(8'h30, 8'h00, 8'h00);
    smp(8'h00, 8'h00, 8'h00);
    smp(8'h30, 8'h00, 8'h00);
    smp(8'h30, 8'h00, 8'h00);
    chk_pin("int2_o", 1'b0, int2);
    smp(8'h30, 8'h00, 8'h00);
    chk_pin("int2_o", 1'b1, int2);
    $display("test duration done");
  endtask : t_dur

  task automatic t_latch();
    cfg(8'h03, 8'h20, 8'h00);
    wb(1'b1, IDX_CONTROL, 32'h0000_0001);
    smp(8'h30, 8'h00, 8'h00);
    smp(8'h10, 8'h00, 8'h00);
    chk_pin("int2_o", 1'b1, int2);
    rdchk(IDX_SOURCE, 32'h0000_0042);
    smp(8'h10, 8'h00, 8'h00);
    rdchk(IDX_SOURCE, 32'h0000_0041);
    rdchk(IDX_IRQ_STATUS, 32'h0000_0003);
    wb(1'b1, IDX_CONTROL, 32'h0000_0000);
    $display("test latched done");
  endtask : t_latch

  task automatic t_six();
    cfg(8'hC3, 8'h20, 8'h00);
    smp(8'hD0, 8'h00, 8'h00);
    rdchk(IDX_SOURCE, 32'h0000_0041);
    cfg(8'h43, 8'h20, 8'h00);
    smp(8'h30, 8'h00, 8'h00);
    rdchk(IDX_SOURCE, 32'h0000_0042);
    smp(8'h30, 8'h00, 8'h00);
    rdchk(IDX_SOURCE, 32'h0000_0000);
    $display("test six_direction done");
  endtask : t_six

  task automatic t_irq();
    wb(1'b1, IDX_IRQ_CLEAR, 32'h0000_0003);
    wb(1'b1, IDX_IRQ_ENABLE, 32'h0000_0001);
    cfg(8'h02, 8'h20, 8'h00);
    chk_pin("irq_o", 1'b0, irq);
    smp(8'h30, 8'h00, 8'h00);
    chk_pin("irq_o", 1'b1, irq);
    rdchk(IDX_IRQ_STATUS, 32'h0000_0001);
    wb(1'b1, IDX_IRQ_ENABLE, 32'h0000_0000);
    chk_pin("irq_o", 1'b0, irq);
    wb(1'b1, IDX_IRQ_ENABLE, 32'h0000_0001);
    chk_pin("irq_o", 1'b1, irq);
    wb(1'b1, IDX_IRQ_CLEAR, 32'h0000_0001);
    chk_pin("irq_o", 1'b0, irq);
    rdchk(IDX_IRQ_STATUS, 32'h0000_0000);
    rdchk(IDX_IRQ_CLEAR, 32'h0000_0000);
    $display("test irq done");
  endtask : t_irq

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_or();
    t_and();
    t_dur();
    t_latch();
    t_six();
    t_irq();
    stop_test();
  end

  // The whole sequence needs a few hundred cycles; this is ample margin
  initial begin
    #(40 * 20000);
    err_count++;
    $display("MISMATCH watchdog expected finish seen timeout");
    stop_test();
  end
endmodule : test_motion_event_interrupt_two
